// ==== core/nad_top.sv ====
// Adapter control: command intake, host DMA with overrun watch, power-up
//
// Summary of operation
// - Host sends each command as three address bytes, each by ready/strobe handshake.
// - Each command byte passes through one single-byte holding register in turn.
// - While a message is active, start a host DMA cycle every 7.25 us.
// - Flag overrun when grant has not returned high within 5.9 us of request.
// - Flag overrun when grant never went low within 5.9 us of request.
// - Overrun blocks link traffic, alerts processor, suppresses next DMA cycle start.
// - After overrun restart block transfer; for receive withhold acknowledgement silently.
// - Power-up reads switches into own node, lights indicator, sets link mode.
// - Initialization clears receive sockets, event counters and parity table.
// - Program memory intact only when low byte of byte sum is zero.
// - Check passed: indicator off, continue; failed: halt with indicator lit.
// - Then set variables, enable link reception, broadcast resync packets.
// - Send eleven resync packets: default retry count ten plus one.
// - Received resync packet clears sender entry in own parity table.
// - Indicator flickers on every transmitted packet in normal operation.
// - Host initialize runs power-up sequence and returns own node number.
// - When initialized, wait for command or packet, service it, wait again.
// - Direction line shows host write or read during each DMA cycle.
`timescale 1ns/1ns

module nad_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 32) (
   input  wire logic             ref_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic [WIDTH-1:0]      out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data_out = mem[rd_ptr];

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr        <= '0;
         rd_ptr        <= '0;
         count         <= '0;
         in_ready_out  <= 1'b0;
         out_valid_out <= 1'b0;
      end else begin
         wr_ptr        <= wr_ptr + AW'(push);
         rd_ptr        <= rd_ptr + AW'(pop);
         count         <= next_count;
         in_ready_out  <= next_count != (AW+1)'(DEPTH);
         out_valid_out <= next_count != '0;
      end
   end
endmodule : nad_fifo

module nad_top import nad_pkg::*; (
   input  wire logic            ref_clk_in,
   input  wire logic            reset_n_in,
   input  wire logic            cmd_strobe_in,
   input  wire logic [7:0]      cmd_data_in,
   output logic                 cmd_ready_out,
   output logic                 cmd_valid_out,
   output logic [23:0]          cmd_vector_out,
   input  wire logic            dma_grant_n,
   input  wire logic [7:0]      dma_data_in,
   output logic                 dma_request_line,
   output logic                 dma_dir_out,
   output logic [7:0]           dma_data_out,
   input  wire logic            msg_active_in,
   input  wire logic            msg_tx_in,
   input  wire logic            rx_valid_in,
   input  wire logic [7:0]      rx_data_in,
   output logic                 rx_ready_out,
   output nad_tx_t              tx_out,
   output logic                 tx_valid_out,
   input  wire logic            tx_ready_in,
   input  wire logic            rx_pkt_valid_in,
   input  wire nad_rxpkt_t      rx_pkt_in,
   output logic                 dup_out,
   output logic                 overrun_out,
   input  wire logic            overrun_clear_in,
   output logic                 ack_withhold_out,
   output logic                 restart_out,
   input  wire logic [7:0]      addr_switch_in,
   output logic [7:0]           own_node_out,
   output logic                 led_out,
   output logic                 link_mode_out,
   output logic                 link_rx_enable_out,
   output logic [SOCKETS-1:0]   socket_active_out,
   input  wire logic [SOCKETS-1:0] socket_setup_in,
   output logic [ROM_AW-1:0]    rom_addr_out,
   input  wire logic [7:0]      rom_data_in,
   input  wire logic            init_cmd_in,
   output logic                 node_return_valid_out,
   output nad_count_t           count_out,
   output logic                 idle_out
);
   localparam int OVR_A = OVR_LIMIT_CYC + 1;
   localparam int PER_A = DMA_PERIOD_CYC - 1;

   // ==========================================
   // Pin synchronisers
   logic [24:0] sync_1;
   logic [24:0] sync_2;
   logic        strobe_d;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync_1   <= {17'h00000, 1'b1, 7'h00};
         sync_2   <= {17'h00000, 1'b1, 7'h00};
         strobe_d <= 1'b0;
      end else begin
         sync_1   <= {cmd_strobe_in, cmd_data_in, dma_data_in, dma_grant_n, addr_switch_in[6:0]};
         sync_2   <= sync_1;
         strobe_d <= sync_2[24];
      end
   end
   logic [7:0] sw_s;
   logic [7:0] sw_hi;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sw_hi <= 8'h00;
         sw_s  <= 8'h00;
      end else begin
         sw_hi <= {7'h00, addr_switch_in[7]};
         sw_s  <= {sw_hi[0], sync_2[6:0]};
      end
   end
   logic       grant_n_s;
   logic [7:0] host_byte_s;
   logic [7:0] cmd_byte_s;
   logic       take;
   assign grant_n_s = sync_2[7];
   assign host_byte_s = sync_2[15:8];
   assign cmd_byte_s = sync_2[23:16];
   assign take = sync_2[24] && !strobe_d && cmd_ready_out;

   nad_init_t state;
   logic      tx_fire;
   assign tx_fire = tx_valid_out && tx_ready_in;

   // ==========================================
   // Command intake
   logic [7:0] hold_byte;
   logic       hold_full;
   logic [1:0] cmd_cnt;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hold_byte      <= 8'h00;
         hold_full      <= 1'b0;
         cmd_cnt        <= 2'h0;
         cmd_ready_out  <= 1'b0;
         cmd_valid_out  <= 1'b0;
         cmd_vector_out <= 24'h000000;
      end else begin
         cmd_valid_out <= 1'b0;
         cmd_ready_out <= (state == I_IDLE) && !take && !hold_full;
         hold_full     <= take;
         if (take) begin
            hold_byte <= cmd_byte_s;
         end
         if (hold_full) begin
            cmd_vector_out <= {cmd_vector_out[15:0], hold_byte};
            cmd_cnt        <= (cmd_cnt == CMD_LAST) ? 2'h0 : cmd_cnt + 2'h1;
            cmd_valid_out  <= cmd_cnt == CMD_LAST;
         end
      end
   end

   // ==========================================
   // Receive buffer toward host memory
   logic       fifo_valid;
   logic [7:0] fifo_data;
   logic       dma_start;
   logic       fifo_pop;
   assign fifo_pop = dma_start && !msg_tx_in;
   nad_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_in   (ref_clk_in),
      .reset_n_in   (reset_n_in),
      .in_valid_in  (rx_valid_in && link_rx_enable_out && !overrun_out),
      .in_data_in   (rx_data_in),
      .in_ready_out (rx_ready_out),
      .out_valid_out(fifo_valid),
      .out_data_out (fifo_data),
      .out_ready_in (fifo_pop)
   );

   // ==========================================
   // Host DMA engine and overrun watch
   nad_dma_t   dma_state;
   logic [8:0] period_cnt;
   logic [9:0] dma_timer;
   logic       ovr_set;
   logic       timeout;
   logic       dma_done;
   assign timeout = dma_timer == 10'(OVR_LIMIT_CYC - 1);
   assign ovr_set = (dma_state != D_IDLE) && timeout;
   assign dma_done = (dma_state == D_WAIT_DONE) && grant_n_s && !timeout;
   assign dma_start = (dma_state == D_IDLE) && msg_active_in && !overrun_out
                      && (period_cnt == 9'(DMA_PERIOD_CYC - 1))
                      && (msg_tx_in ? !tx_valid_out : fifo_valid);

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         period_cnt <= 9'h000;
      end else if (!msg_active_in || dma_start) begin
         period_cnt <= 9'h000;
      end else if (period_cnt != 9'(DMA_PERIOD_CYC - 1) && !overrun_out) begin
         period_cnt <= period_cnt + 9'h001;
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dma_state        <= D_IDLE;
         dma_timer        <= 10'h000;
         dma_request_line <= 1'b0;
         dma_dir_out      <= 1'b0;
         dma_data_out     <= 8'h00;
      end else begin
         dma_timer <= (dma_state == D_IDLE) ? 10'h000 : dma_timer + 10'h001;
         case (dma_state)
            D_IDLE: begin
               if (dma_start) begin
                  dma_state        <= D_WAIT_GO;
                  dma_request_line <= 1'b1;
                  dma_dir_out      <= !msg_tx_in;
                  dma_data_out     <= fifo_data;
               end
            end
            D_WAIT_GO: begin
               if (ovr_set) begin
                  dma_state        <= D_IDLE;
                  dma_request_line <= 1'b0;
               end else if (!grant_n_s) begin
                  dma_state <= D_WAIT_DONE;
               end
            end
            D_WAIT_DONE: begin
               if (ovr_set || dma_done) begin
                  dma_state        <= D_IDLE;
                  dma_request_line <= 1'b0;
               end
            end
            default: begin
               dma_state        <= D_IDLE;
               dma_request_line <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         overrun_out      <= 1'b0;
         ack_withhold_out <= 1'b0;
         restart_out      <= 1'b0;
      end else begin
         restart_out <= overrun_out && overrun_clear_in && !ack_withhold_out;
         if (ovr_set) begin
            overrun_out <= 1'b1;
            ack_withhold_out <= dma_dir_out;
         end else if (overrun_clear_in) begin
            overrun_out      <= 1'b0;
            ack_withhold_out <= 1'b0;
         end
      end
   end

   // ==========================================
   // Power-up and initialize sequence
   logic [10:0] step_cnt;
   logic [7:0]  rom_sum;
   logic        rom_rd_d;
   logic        init_pending;
   logic [3:0]  sync_sent;
   logic        rom_ok;
   assign rom_ok = (rom_sum + rom_data_in) == 8'h00;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= I_SWITCH;
         step_cnt <= 11'h000;
         rom_addr_out <= '0;
         rom_sum <= 8'h00;
         rom_rd_d <= 1'b0;
         init_pending <= 1'b0;
         sync_sent <= 4'h0;
         own_node_out <= 8'h00;
         led_out <= 1'b0;
         link_mode_out <= 1'b0;
         link_rx_enable_out <= 1'b0;
         node_return_valid_out <= 1'b0;
      end else begin
         rom_rd_d <= state == I_ROM;
         node_return_valid_out <= 1'b0;
         if (rom_rd_d) begin
            rom_sum <= rom_sum + rom_data_in;
         end
         if (init_cmd_in && state == I_IDLE) begin
            state <= I_SWITCH;
            init_pending <= 1'b1;
            step_cnt <= 11'h000;
         end else begin
            case (state)
               I_SWITCH: begin
                  step_cnt <= step_cnt + 11'h001;
                  if (step_cnt == 11'(SW_SETTLE)) begin
                     own_node_out <= sw_s;
                     state <= I_LED;
                  end
               end
               I_LED: begin
                  led_out <= 1'b1;
                  state <= I_LINK;
               end
               I_LINK: begin
                  link_mode_out <= 1'b1;
                  link_rx_enable_out <= 1'b0;
                  state <= I_SOCK;
               end
               I_SOCK: state <= I_ZERO;
               I_ZERO: begin
                  step_cnt <= 11'h000;
                  rom_addr_out <= '0;
                  rom_sum <= 8'h00;
                  state <= I_ROM;
               end
               I_ROM: begin
                  rom_addr_out <= rom_addr_out + 11'h001;
                  if (rom_addr_out == ROM_LAST) begin
                     state <= I_CHECK;
                  end
               end
               I_CHECK: begin
                  led_out <= !rom_ok;
                  state <= rom_ok ? I_VARS : I_HALT;
               end
               I_HALT: led_out <= 1'b1;
               I_VARS: begin
                  sync_sent <= 4'h0;
                  state <= I_RXEN;
               end
               I_RXEN: begin
                  link_rx_enable_out <= 1'b1;
                  state <= I_SYNC;
               end
               I_SYNC: begin
                  led_out <= tx_fire;
                  if (tx_fire && tx_out.sync) begin
                     sync_sent <= sync_sent + 4'h1;
                     if (sync_sent == SYNC_LAST) begin
                        state <= I_IDLE;
                        node_return_valid_out <= init_pending;
                        init_pending <= 1'b0;
                     end
                  end
               end
               I_IDLE: begin
                  led_out <= tx_fire;
                  if (cmd_valid_out || rx_pkt_valid_in) begin
                     state <= I_SERVICE;
                  end
               end
               I_SERVICE: begin
                  led_out <= tx_fire;
                  state <= I_IDLE;
               end
               default: state <= I_SWITCH;
            endcase
         end
      end
   end
   // Registered flag that the main-loop state is I_IDLE, one cycle behind
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         idle_out <= 1'b0;
      end else begin
         idle_out <= state == I_IDLE;
      end
   end

   // ==========================================
   // Transmit path, sockets, counters and parity table
   logic [255:0] parity_tbl;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_valid_out <= 1'b0;
         tx_out <= '0;
         socket_active_out <= '0;
         count_out <= '0;
         parity_tbl <= '0;
         dup_out <= 1'b0;
      end else begin
         if (tx_fire) begin
            tx_valid_out <= 1'b0;
         end else if (state == I_SYNC && !tx_valid_out) begin
            tx_valid_out <= 1'b1;
            tx_out <= '{data: own_node_out, sync: 1'b1};
         end else if (dma_done && !dma_dir_out) begin
            tx_valid_out <= 1'b1;
            tx_out <= '{data: host_byte_s, sync: 1'b0};
         end
         if (state == I_SOCK) begin
            socket_active_out <= '0;
         end else begin
            socket_active_out <= socket_active_out | socket_setup_in;
         end
         if (state == I_ZERO) begin
            count_out <= '0;
            parity_tbl <= '0;
         end else begin
            count_out.tx <= count_out.tx + 8'(tx_fire);
            count_out.ovr <= count_out.ovr + 8'(ovr_set);
            count_out.rx <= count_out.rx + 8'(rx_pkt_valid_in && link_rx_enable_out);
            if (rx_pkt_valid_in && link_rx_enable_out) begin
               if (rx_pkt_in.resync) begin
                  parity_tbl[rx_pkt_in.src] <= 1'b0;
                  dup_out <= 1'b0;
               end else begin
                  dup_out <= parity_tbl[rx_pkt_in.src] == rx_pkt_in.parity;
                  parity_tbl[rx_pkt_in.src] <= rx_pkt_in.parity;
               end
            end
         end
      end
   end

   // ==========================================
   // Checks
   sequence s_take;
      sync_2[24] && !strobe_d && cmd_ready_out;
   endsequence
   property p_hold;
      @(posedge ref_clk_in) disable iff (!reset_n_in) s_take |=> hold_full && !cmd_ready_out;
   endproperty
   a_hold: assert property (p_hold) else $error("byte not held");
   property p_vector;
      @(posedge ref_clk_in) disable iff (!reset_n_in) cmd_valid_out |-> $past(cmd_cnt) == 2'h2;
   endproperty
   a_vector: assert property (p_vector) else $error("vector not three bytes");
   property p_period;
      @(posedge ref_clk_in) disable iff (!reset_n_in) dma_start |-> period_cnt == 9'(PER_A);
   endproperty
   a_period: assert property (p_period) else $error("DMA start spacing wrong");
   sequence s_req_stuck;
      $rose(dma_request_line) ##1 dma_request_line [*8];
   endsequence
   property p_ovr;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         s_req_stuck |-> ##[1:OVR_A] (!dma_request_line || overrun_out);
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun missed");
   property p_early;
      @(posedge ref_clk_in) disable iff (!reset_n_in) $rose(overrun_out) |-> $past(dma_timer) == 10'(OVR_A - 2);
   endproperty
   a_early: assert property (p_early) else $error("overrun at wrong time");
   property p_block;
      @(posedge ref_clk_in) disable iff (!reset_n_in) overrun_out |-> !dma_start && !dma_request_line;
   endproperty
   a_block: assert property (p_block) else $error("DMA not blocked");
   property p_sticky;
      @(posedge ref_clk_in) disable iff (!reset_n_in) overrun_out && !overrun_clear_in |=> overrun_out;
   endproperty
   a_sticky: assert property (p_sticky) else $error("overrun dropped");
   property p_halt;
      @(posedge ref_clk_in) disable iff (!reset_n_in) state == I_HALT |=> led_out && state == I_HALT;
   endproperty
   a_halt: assert property (p_halt) else $error("halt left");
   property p_sync;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         $past(state) == I_SYNC && state == I_IDLE |-> sync_sent == 4'hB;
   endproperty
   a_sync: assert property (p_sync) else $error("resync count wrong");
   property p_dir;
      @(posedge ref_clk_in) disable iff (!reset_n_in) dma_request_line && $past(dma_request_line) |-> $stable(dma_dir_out);
   endproperty
   a_dir: assert property (p_dir) else $error("direction moved");
endmodule : nad_top

// ==== core/nad_pkg.sv ====
// Shared constants, states and carriers of the adapter control block
package nad_pkg;
   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS  = 20;
   localparam int DMA_PERIOD_NS  = 7250;
   localparam int DMA_PERIOD_CYC = DMA_PERIOD_NS / CLK_PERIOD_NS;
   localparam int OVR_LIMIT_NS   = 5900;
   localparam int OVR_LIMIT_CYC  = OVR_LIMIT_NS / CLK_PERIOD_NS;
   localparam int HOST_DONE_NS   = 12000;
   localparam int HOST_DONE_CYC  = HOST_DONE_NS / CLK_PERIOD_NS;
   // ==========================================
   // Sizes and values
   localparam logic [3:0] RETRY_DEFAULT = 4'hA;
   localparam logic [3:0] SYNC_LAST     = RETRY_DEFAULT;
   localparam logic [1:0] CMD_LAST      = 2'h2;
   localparam int         ROM_AW        = 11;
   localparam logic [10:0] ROM_LAST     = 11'h7FF;
   localparam int         SOCKETS       = 4;
   localparam int         FIFO_W        = 8;
   localparam int         FIFO_DEPTH    = 32;
   localparam int         SW_SETTLE     = 3;
   // ==========================================
   // States
   typedef enum logic [3:0] {
      I_SWITCH = 4'h0, I_LED = 4'h1, I_LINK = 4'h2, I_SOCK = 4'h3,
      I_ZERO = 4'h4, I_ROM = 4'h5, I_CHECK = 4'h6, I_HALT = 4'h7,
      I_VARS = 4'h8, I_RXEN = 4'h9, I_SYNC = 4'hA, I_IDLE = 4'hB,
      I_SERVICE = 4'hC
   } nad_init_t;
   typedef enum logic [1:0] {
      D_IDLE = 2'h0, D_WAIT_GO = 2'h1, D_WAIT_DONE = 2'h2
   } nad_dma_t;
   // ==========================================
   // Carriers
   typedef struct packed {
      logic [7:0] data;
      logic       sync;
   } nad_tx_t;
   typedef struct packed {
      logic [7:0] src;
      logic       parity;
      logic       resync;
   } nad_rxpkt_t;
   typedef struct packed {
      logic [7:0] tx;
      logic [7:0] rx;
      logic [7:0] ovr;
   } nad_count_t;
endpackage : nad_pkg

// ==== testbench/nad_host_model.sv ====
// Host bus model that grants DMA after a chosen delay
`timescale 1ns/1ns
module nad_host_model (
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic       dma_request_line,
   input  wire logic [9:0] go_dly_in,
   output logic            dma_grant_n,
   output logic [7:0]      dma_data_in
);
   logic [9:0] cnt;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt <= 10'h000;
         dma_grant_n <= 1'b1;
      end else if (!dma_request_line) begin
         cnt <= 10'h000;
         dma_grant_n <= 1'b1;
      end else begin
         cnt <= cnt + 10'h001;
         dma_grant_n <= !(cnt >= go_dly_in && cnt < go_dly_in + 10'h004);
      end
   end
   // Bus data is only meaningful while granted
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dma_data_in <= 8'h00;
      end else begin
         dma_data_in <= dma_grant_n ? ~dma_data_in : 8'h5A;
      end
   end
endmodule : nad_host_model

// ==== testbench/tb.sv ====
// Self-checking bench of the adapter control block
`timescale 1ns/1ns
module tb;
   import nad_pkg::*;
   logic ref_clk_in, reset_n_in, cmd_strobe_in, dma_grant_n, msg_active_in, tx_ready_in;
   logic rx_valid_in, overrun_clear_in, cmd_ready_out, cmd_valid_out, dma_request_line;
   logic tx_valid_out, overrun_out, ack_withhold_out, led_out, idle_out;
   logic msg_tx_in, init_cmd_in, dma_dir_out, restart_out, link_mode_out, link_rx_enable_out;
   logic node_return_valid_out;
   logic [7:0] dma_data_out, own_node_out;
   nad_count_t count_out;
   logic [7:0] cmd_data_in, dma_data_in, rx_data_in, addr_switch_in;
   logic [23:0] cmd_vector_out;
   logic [9:0] go_dly;
   logic [31:0] seed = 32'h91908FCA;
   nad_tx_t tx_out;
   nad_rxpkt_t rx_pkt_in;
   logic [23:0] q_cmd[$];
   nad_tx_t q_tx[$];
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int gap;
   nad_top dut (.ref_clk_in, .reset_n_in, .cmd_strobe_in, .cmd_data_in, .cmd_ready_out,
      .cmd_valid_out, .cmd_vector_out, .dma_grant_n, .dma_data_in, .dma_request_line,
      .dma_dir_out, .dma_data_out, .msg_active_in, .msg_tx_in, .rx_valid_in,
      .rx_data_in, .rx_ready_out(), .tx_out, .tx_valid_out, .tx_ready_in,
      .rx_pkt_valid_in(1'b0), .rx_pkt_in, .dup_out(), .overrun_out, .overrun_clear_in,
      .ack_withhold_out, .restart_out, .addr_switch_in, .own_node_out, .led_out,
      .link_mode_out, .link_rx_enable_out, .socket_active_out(),
      .socket_setup_in(4'h0), .rom_addr_out(), .rom_data_in(8'h00), .init_cmd_in,
      .node_return_valid_out, .count_out, .idle_out);
   nad_host_model host (.ref_clk_in, .reset_n_in, .dma_request_line, .go_dly_in(go_dly),
      .dma_grant_n, .dma_data_in);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (n_errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : tick
   task automatic send_cmd(input logic [23:0] v);
      q_cmd.push_back(v);
      for (int i = 2; i >= 0; i--) begin
         while (cmd_ready_out !== 1'b1) tick(1);
         cmd_data_in <= v[8*i +: 8];
         cmd_strobe_in <= 1'b1;
         tick(5);
         cmd_strobe_in <= 1'b0;
         tick(5);
      end
   endtask : send_cmd
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   // Random stall of the link and noise on the packet inputs, plus hang guard
   always @(posedge ref_clk_in) begin
      seed <= xs(seed);
      tx_ready_in <= seed[0];
      rx_pkt_in <= seed[10:1];
      cyc++;
      if (cyc == 12000) begin
         chk(1'b0, "timeout");
         tally_and_finish();
      end
   end
   // Results taken off the queues as they appear
   always @(posedge ref_clk_in) begin
      if (cmd_valid_out === 1'b1) begin
         chk(q_cmd.size() > 0 && cmd_vector_out === q_cmd[0], "vector");
         if (q_cmd.size() > 0) void'(q_cmd.pop_front());
      end
      if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
         chk(q_tx.size() > 0 && tx_out === q_tx[0], "resync byte");
         if (q_tx.size() > 0) void'(q_tx.pop_front());
      end
   end
   initial begin
      {reset_n_in, cmd_strobe_in, msg_active_in, rx_valid_in, overrun_clear_in} = '0;
      {msg_tx_in, init_cmd_in} = '0;
      {cmd_data_in, rx_data_in} = '0;
      go_dly = 10'd5;
      addr_switch_in = 8'h5B;
      for (int i = 0; i < 11; i++) q_tx.push_back('{data: 8'h5B, sync: 1'b1});
      tick(3);
      reset_n_in <= 1'b1;
      tick(10);
      chk(led_out === 1'b1, "led dark in init");
      while (idle_out !== 1'b1) tick(1);
      tick(3);
      chk(led_out === 1'b0 && q_tx.size() == 0, "init end");
      chk(own_node_out === 8'h5B && link_mode_out === 1'b1, "node or mode");
      chk(link_rx_enable_out === 1'b1, "rx not enabled");
      chk(count_out === 24'h0B0000, "counters");
      send_cmd(seed[23:0]);
      send_cmd(~seed[31:8]);
      tick(8);
      chk(q_cmd.size() == 0, "vector count");
      rx_valid_in <= 1'b1;
      rx_data_in <= 8'hC3;
      tick(10);
      rx_valid_in <= 1'b0;
      msg_active_in <= 1'b1;
      while (dma_request_line !== 1'b1) tick(1);
      chk(dma_dir_out === 1'b1 && dma_data_out === 8'hC3, "write cycle");
      while (dma_request_line !== 1'b0) tick(1);
      gap = 0;
      while (dma_request_line !== 1'b1 && gap < 500) begin
         tick(1);
         gap++;
      end
      chk(gap >= 340 && gap <= 370, "dma spacing");
      tick(700);
      chk(overrun_out === 1'b0, "overrun with prompt host");
      go_dly <= 10'd400;
      tick(1100);
      chk(overrun_out === 1'b1 && ack_withhold_out === 1'b1, "no overrun");
      gap = 0;
      repeat (400) begin
         tick(1);
         if (dma_request_line !== 1'b0) gap++;
      end
      chk(gap == 0 && overrun_out === 1'b1, "start during overrun");
      msg_active_in <= 1'b0;
      overrun_clear_in <= 1'b1;
      tick(1);
      overrun_clear_in <= 1'b0;
      tick(3);
      chk(overrun_out === 1'b0, "overrun not cleared");
      msg_tx_in <= 1'b1;
      msg_active_in <= 1'b1;
      go_dly <= 10'd5;
      while (dma_request_line !== 1'b1) tick(1);
      q_tx.push_back('{data: 8'h5A, sync: 1'b0});
      chk(dma_dir_out === 1'b0, "read direction");
      while (dma_request_line !== 1'b0) tick(1);
      go_dly <= 10'd400;
      while (overrun_out !== 1'b1) tick(1);
      chk(ack_withhold_out === 1'b0, "ack withheld on read");
      msg_active_in <= 1'b0;
      overrun_clear_in <= 1'b1;
      tick(1);
      overrun_clear_in <= 1'b0;
      tick(1);
      chk(restart_out === 1'b1 && q_tx.size() == 0, "no restart");
      chk(count_out[7:0] === 8'h02, "overrun count");
      for (int i = 0; i < 11; i++) q_tx.push_back('{data: 8'h5B, sync: 1'b1});
      init_cmd_in <= 1'b1;
      tick(1);
      init_cmd_in <= 1'b0;
      while (node_return_valid_out !== 1'b1) tick(1);
      chk(own_node_out === 8'h5B && q_tx.size() == 0, "no node return");
      chk(count_out === 24'h0B0000, "counters not cleared");
      tally_and_finish();
   end
endmodule : tb
